// *** hdl/wocfg_option_regs.sv ***
// Contract
// - Each configuration register takes exactly one write after every reset.
// - Any reset clears every configuration register bit.
// - Configuration registers read their contents at any time.
// - Watchdog rate bit picks 8176 cycles when set, 262128 when clear.
// - Low-voltage-in-stop keeps monitor running in stop if a detector is on.
// - Low-voltage reset disable blocks monitor resets; clear lets them pass.
// - Monitor disable bits switch off supply and regulator detectors.
// - Short stop recovery picks 32 cycles when set, 4096 when clear.
// - Leaving stop through reset always uses the long recovery delay.
// - Stop enable clear makes the STOP instruction illegal.
// - Watchdog disable bit set disables the watchdog.
// - Internal oscillator stop-off set halts it in stop.
// - RC stop-keep set keeps the RC oscillator running in stop.
// - Crystal stop-keep set keeps the crystal running in stop.
// - Timebase select routes internal, RC or crystal; reset clears it.
// - Baud select uses bus clock when set, main oscillator clock when clear.
// - Option byte selects main oscillator; erased ones; reset leaves it.
// - Option byte changes only by flash programming, never by a bus write while programming is off.
// - Option byte is protected; only mass erase sets it back to erased ones.
//
// Local design decision: the AHB-Lite slave port.
module wocfg_option_regs
   import wocfg_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic [31:0]  hwdata,
   input  wire logic         hready,
   output logic      [31:0]  hrdata,
   output logic              hreadyout,
   output logic              hresp,
   input  wire logic         flashProgEnable,
   input  wire logic         flashMassErase,
   input  wire wocfg_sysin_t sysIn,
   output logic              watchdogDisable,
   output logic      [17:0]  watchdogTimeout,
   output logic              supplyMonitorEnable,
   output logic              regulatorMonitorEnable,
   output logic              lowvoltMonitorInStop,
   output logic              lowvoltResetOut,
   output logic      [12:0]  stopRecoveryDelay,
   output logic              stopInstrEnable,
   output logic              internalOscStopRun,
   output logic              rcOscStopRun,
   output logic              crystalOscStopRun,
   output wocfg_tbsel_t      timebaseClockSelect,
   output logic              serialBaudFromBus,
   output wocfg_mosel_t      mainOscSelect
);

   // ************************************************************
   // Bus slave
   // ************************************************************
   logic        wrPend_ff;
   logic [17:0] wrAddr_ff;
   logic [7:0]  cfgOne_ff;
   logic [7:0]  cfgTwo_ff;
   logic        oneLocked_ff;
   logic        twoLocked_ff;
   logic [7:0]  oscOpt_ff;
   logic [1:0]  lvRstSync_ff;
   logic [1:0]  stopRstSync_ff;
   logic [7:0]  rdByte;
   logic        addrPhase;

   assign addrPhase = hsel && hready && htrans[1];

   always_comb begin
      unique case (haddr[17:0])
         CFG_ONE_ADDR: rdByte = cfgOne_ff;
         CFG_TWO_ADDR: rdByte = cfgTwo_ff;
         OSC_OPT_ADDR: rdByte = oscOpt_ff;
         default:      rdByte = CFG_RESET;
      endcase
   end

   // Zero wait states; reads are registered at the address phase edge.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wrPend_ff <= 1'b0;
         wrAddr_ff <= 18'h0_0000;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wrPend_ff <= addrPhase && hwrite;
         if (addrPhase) begin
            wrAddr_ff <= haddr[17:0];
         end
         if (addrPhase && !hwrite) begin
            hrdata <= {24'h00_0000, rdByte};
         end
      end
   end

   // ************************************************************
   // Write-once configuration registers
   // ************************************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfgOne_ff    <= CFG_RESET;
         oneLocked_ff <= 1'b0;
      end else if (wrPend_ff && wrAddr_ff == CFG_ONE_ADDR && !oneLocked_ff) begin
         cfgOne_ff    <= hwdata[7:0];
         oneLocked_ff <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfgTwo_ff    <= CFG_RESET;
         twoLocked_ff <= 1'b0;
      end else if (wrPend_ff && wrAddr_ff == CFG_TWO_ADDR && !twoLocked_ff) begin
         // Unimplemented bits 2 and 1 stay zero.
         cfgTwo_ff    <= hwdata[7:0] & CFG_TWO_MASK;
         twoLocked_ff <= 1'b1;
      end
   end

   // ************************************************************
   // Option byte in flash
   // ************************************************************
   // The cell has no reset: flash contents survive it. A plain bus
   // write to the option offset does nothing; only the programming
   // port clears bits, and only mass erase sets them back.
   always_ff @(posedge clk) begin
      if (flashMassErase) begin
         oscOpt_ff <= OSC_ERASED;
      end else if (flashProgEnable && wrPend_ff && wrAddr_ff == OSC_PROG_ADDR) begin
         oscOpt_ff <= oscOpt_ff & hwdata[7:0];
      end
   end

   // ************************************************************
   // Reset request inputs from other clocking
   // ************************************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lvRstSync_ff   <= 2'b00;
         stopRstSync_ff <= 2'b00;
      end else begin
         lvRstSync_ff   <= {lvRstSync_ff[0], sysIn.lowvoltMonitorReset};
         stopRstSync_ff <= {stopRstSync_ff[0], sysIn.stopExitByReset};
      end
   end

   // ************************************************************
   // Decoded control outputs
   // ************************************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         watchdogDisable        <= 1'b0;
         watchdogTimeout        <= WDG_LONG_CYC;
         supplyMonitorEnable    <= 1'b1;
         regulatorMonitorEnable <= 1'b1;
         lowvoltMonitorInStop   <= 1'b0;
         lowvoltResetOut        <= 1'b0;
         stopRecoveryDelay      <= REC_LONG_CYC;
         stopInstrEnable        <= 1'b0;
         internalOscStopRun     <= 1'b1;
         rcOscStopRun           <= 1'b0;
         crystalOscStopRun      <= 1'b0;
         timebaseClockSelect    <= WOCFG_TB_INT;
         serialBaudFromBus      <= 1'b0;
      end else begin
         watchdogDisable        <= cfgOne_ff[WDG_DIS_BIT];
         watchdogTimeout        <= cfgOne_ff[WDG_RATE_BIT] ? WDG_SHORT_CYC
                                                          : WDG_LONG_CYC;
         supplyMonitorEnable    <= !cfgOne_ff[SUP_MOND_BIT];
         regulatorMonitorEnable <= !cfgOne_ff[REG_MOND_BIT];
         lowvoltMonitorInStop   <= cfgOne_ff[LV_STOP_BIT] &&
                                   !(cfgOne_ff[SUP_MOND_BIT] && cfgOne_ff[REG_MOND_BIT]);
         lowvoltResetOut        <= lvRstSync_ff[1] && !cfgOne_ff[LV_RSTD_BIT];
         // A reset exit restarts the oscillator, so the short delay is unsafe.
         stopRecoveryDelay      <= (cfgOne_ff[SHORT_STOP_RECOVERY_BIT] && !stopRstSync_ff[1]) ?
                                   REC_SHORT_CYC : REC_LONG_CYC;
         stopInstrEnable        <= cfgOne_ff[STOP_EN_BIT];
         internalOscStopRun     <= !cfgTwo_ff[INTERNAL_OSC_CLOCK_OFF_BIT];
         rcOscStopRun           <= cfgTwo_ff[RC_KEEP_BIT];
         crystalOscStopRun      <= cfgTwo_ff[XT_KEEP_BIT];
         timebaseClockSelect    <= wocfg_tbsel_t'({cfgTwo_ff[TB_SEL_HI_BIT],
                                                   cfgTwo_ff[TB_SEL_LO_BIT]});
         serialBaudFromBus      <= cfgTwo_ff[BAUD_SEL_BIT];
      end
   end

   // The flash cell has no reset, so neither does its decoded copy.
   always_ff @(posedge clk) begin
      mainOscSelect <= wocfg_mosel_t'({oscOpt_ff[MOSC_HI_BIT], oscOpt_ff[MOSC_LO_BIT]});
   end

   // ************************************************************
   // Checks
   // ************************************************************
   logic wrOneFirst;
   assign wrOneFirst = wrPend_ff && wrAddr_ff == CFG_ONE_ADDR && !oneLocked_ff;

   once_lock_a: assert property (@(posedge clk) disable iff (!reset_n)
      oneLocked_ff && !wrOneFirst |=> $stable(cfgOne_ff))
      else $error("Locked config one changed.");
   first_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      wrOneFirst |=> cfgOne_ff == $past(hwdata[7:0]) && oneLocked_ff)
      else $error("First write not latched.");
   two_lock_a: assert property (@(posedge clk) disable iff (!reset_n)
      twoLocked_ff |=> $stable(cfgTwo_ff) && twoLocked_ff)
      else $error("Locked config two changed.");
   read_back_a: assert property (@(posedge clk) disable iff (!reset_n)
      addrPhase && !hwrite && haddr[17:0] == CFG_ONE_ADDR
      |=> hrdata[7:0] == $past(cfgOne_ff))
      else $error("Config one read mismatch.");
   wdg_rate_a: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 watchdogTimeout == ($past(cfgOne_ff[WDG_RATE_BIT]) ? 18'd8176 : 18'd262128))
      else $error("Watchdog timeout wrong.");
   lv_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
      lowvoltResetOut |-> !$past(cfgOne_ff[LV_RSTD_BIT]))
      else $error("Monitor reset passed while disabled.");
   rec_delay_a: assert property (@(posedge clk) disable iff (!reset_n)
      stopRstSync_ff[1] |=> stopRecoveryDelay == 13'd4096)
      else $error("Reset exit used short recovery.");
   stop_en_a: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 stopInstrEnable == $past(cfgOne_ff[STOP_EN_BIT]))
      else $error("Stop enable not following its bit.");
   opt_bus_a: assert property (@(posedge clk) disable iff (!reset_n)
      !$past(flashProgEnable) && !$past(flashMassErase) |-> $stable(oscOpt_ff))
      else $error("Option byte changed without programming.");

   // ************************************************************
   // Decode and storage checks
   // ************************************************************
   // Every decoded output is a flop fed from the registers, so each check
   // looks one edge after the bit it follows. The option byte is unknown
   // until the first erase, so its checks start from an erase, a programming write or a read.

   wdg_dis_a: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 watchdogDisable == $past(cfgOne_ff[WDG_DIS_BIT]))
      else $error("Watchdog disable not following its bit.");

   wdg_short_a: assert property (@(posedge clk) disable iff (!reset_n)
      cfgOne_ff[WDG_RATE_BIT]
      |=> watchdogTimeout == WDG_SHORT_CYC)
      else $error("Short watchdog timeout not chosen.");

   wdg_long_a: assert property (@(posedge clk) disable iff (!reset_n)
      !cfgOne_ff[WDG_RATE_BIT]
      |=> watchdogTimeout == WDG_LONG_CYC)
      else $error("Long watchdog timeout not chosen.");

   sup_mon_a: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 supplyMonitorEnable == !$past(cfgOne_ff[SUP_MOND_BIT]))
      else $error("Supply monitor enable wrong.");

   reg_mon_a: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 regulatorMonitorEnable == !$past(cfgOne_ff[REG_MOND_BIT]))
      else $error("Regulator monitor enable wrong.");

   lv_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
      cfgOne_ff[LV_STOP_BIT] && !(cfgOne_ff[SUP_MOND_BIT] && cfgOne_ff[REG_MOND_BIT])
      |=> lowvoltMonitorInStop)
      else $error("Monitor not kept in stop.");

   lv_stop_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      !cfgOne_ff[LV_STOP_BIT]
      |=> !lowvoltMonitorInStop)
      else $error("Monitor kept in stop while not asked.");

   lv_pass_a: assert property (@(posedge clk) disable iff (!reset_n)
      lvRstSync_ff[1] && !cfgOne_ff[LV_RSTD_BIT]
      |=> lowvoltResetOut)
      else $error("Monitor reset not passed.");

   lv_block_a: assert property (@(posedge clk) disable iff (!reset_n)
      cfgOne_ff[LV_RSTD_BIT]
      |=> !lowvoltResetOut)
      else $error("Monitor reset not blocked.");

   rec_short_a: assert property (@(posedge clk) disable iff (!reset_n)
      cfgOne_ff[SHORT_STOP_RECOVERY_BIT] && !stopRstSync_ff[1]
      |=> stopRecoveryDelay == REC_SHORT_CYC)
      else $error("Short recovery not chosen.");

   rec_long_a: assert property (@(posedge clk) disable iff (!reset_n)
      !cfgOne_ff[SHORT_STOP_RECOVERY_BIT]
      |=> stopRecoveryDelay == REC_LONG_CYC)
      else $error("Long recovery not chosen.");

   stop_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      !cfgOne_ff[STOP_EN_BIT]
      |=> !stopInstrEnable)
      else $error("Stop allowed while disabled.");

   int_osc_a: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 internalOscStopRun == !$past(cfgTwo_ff[INTERNAL_OSC_CLOCK_OFF_BIT]))
      else $error("Internal oscillator stop control wrong.");

   rc_osc_a: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 rcOscStopRun == $past(cfgTwo_ff[RC_KEEP_BIT]))
      else $error("RC oscillator stop control wrong.");

   xt_osc_a: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 crystalOscStopRun == $past(cfgTwo_ff[XT_KEEP_BIT]))
      else $error("Crystal stop control wrong.");

   tb_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 timebaseClockSelect == $past({cfgTwo_ff[TB_SEL_HI_BIT], cfgTwo_ff[TB_SEL_LO_BIT]}))
      else $error("Timebase select wrong.");

   baud_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 serialBaudFromBus == $past(cfgTwo_ff[BAUD_SEL_BIT]))
      else $error("Baud source select wrong.");

   main_osc_a: assert property (@(posedge clk) disable iff (!reset_n)
      flashMassErase
      |=> ##1 mainOscSelect == WOCFG_MO_XTAL)
      else $error("Erased option byte not decoded.");

   opt_erase_a: assert property (@(posedge clk) disable iff (!reset_n)
      flashMassErase
      |=> oscOpt_ff == OSC_ERASED)
      else $error("Mass erase did not restore option byte.");

   opt_prog_a: assert property (@(posedge clk) disable iff (!reset_n)
      flashProgEnable && wrPend_ff && wrAddr_ff == OSC_PROG_ADDR && !flashMassErase
      |=> (oscOpt_ff & ~$past(hwdata[7:0])) == 8'h00)
      else $error("Programming set an option bit.");

   cfg_reset_a: assert property (@(posedge clk)
      !reset_n
      |-> cfgOne_ff == CFG_RESET && cfgTwo_ff == CFG_RESET)
      else $error("Config registers not cleared in reset.");

   lock_reset_a: assert property (@(posedge clk)
      !reset_n
      |-> !oneLocked_ff && !twoLocked_ff)
      else $error("Write locks not cleared in reset.");

   two_first_a: assert property (@(posedge clk) disable iff (!reset_n)
      wrPend_ff && wrAddr_ff == CFG_TWO_ADDR && !twoLocked_ff
      |=> cfgTwo_ff == ($past(hwdata[7:0]) & CFG_TWO_MASK) && twoLocked_ff)
      else $error("First config two write not latched.");

   two_unimpl_a: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 cfgTwo_ff[2:1] == 2'b00)
      else $error("Unimplemented config two bits set.");

   one_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      oneLocked_ff
      |=> oneLocked_ff)
      else $error("Config one lock dropped.");

   read_two_a: assert property (@(posedge clk) disable iff (!reset_n)
      addrPhase && !hwrite && haddr[17:0] == CFG_TWO_ADDR
      |=> hrdata[7:0] == $past(cfgTwo_ff))
      else $error("Config two read mismatch.");

   read_high_a: assert property (@(posedge clk) disable iff (!reset_n)
      addrPhase && !hwrite
      |=> hrdata[31:8] == 24'h00_0000)
      else $error("Read data upper bits not zero.");

   read_opt_a: assert property (@(posedge clk) disable iff (!reset_n)
      addrPhase && !hwrite && haddr[17:0] == OSC_OPT_ADDR
      |=> hrdata[7:0] == $past(oscOpt_ff))
      else $error("Option byte read mismatch.");

   bus_okay_a: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 hreadyout && !hresp)
      else $error("Bus response not ready and okay.");

endmodule

// *** hdl/wocfg_pkg.sv ***
package wocfg_pkg;

   // ************************************************************
   // Register offsets
   // ************************************************************
   // Printed offsets are not all multiples of four, so they are indices.
   localparam logic [15:0] CFG_TWO_IDX    = 16'h001D;
   localparam logic [15:0] CFG_ONE_IDX    = 16'h001F;
   localparam logic [15:0] OSC_OPT_IDX    = 16'hFFCF;
   localparam logic [17:0] CFG_TWO_ADDR   = {CFG_TWO_IDX, 2'b00};
   localparam logic [17:0] CFG_ONE_ADDR   = {CFG_ONE_IDX, 2'b00};
   localparam logic [17:0] OSC_OPT_ADDR   = {OSC_OPT_IDX, 2'b00};
   // Flash programming interface image of the option byte.
   localparam logic [17:0] OSC_PROG_ADDR  = 18'h0_0100;

   // ************************************************************
   // Reset and erased values
   // ************************************************************
   localparam logic [7:0]  CFG_RESET      = 8'h00;
   localparam logic [7:0]  OSC_ERASED     = 8'hFF;
   localparam logic [7:0]  CFG_TWO_MASK   = 8'hF9;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int WDG_RATE_BIT   = 7;
   localparam int LV_STOP_BIT    = 6;
   localparam int LV_RSTD_BIT    = 5;
   localparam int SUP_MOND_BIT   = 4;
   localparam int REG_MOND_BIT   = 3;
   localparam int SHORT_STOP_RECOVERY_BIT      = 2;
   localparam int STOP_EN_BIT    = 1;
   localparam int WDG_DIS_BIT    = 0;
   localparam int INTERNAL_OSC_CLOCK_OFF_BIT   = 7;
   localparam int RC_KEEP_BIT    = 6;
   localparam int XT_KEEP_BIT    = 5;
   localparam int TB_SEL_HI_BIT  = 4;
   localparam int TB_SEL_LO_BIT  = 3;
   localparam int BAUD_SEL_BIT   = 0;
   localparam int MOSC_HI_BIT    = 7;
   localparam int MOSC_LO_BIT    = 6;

   // ************************************************************
   // Timing counts, in internal oscillator cycles
   // ************************************************************
   localparam logic [17:0] WDG_SHORT_CYC  = 18'd8176;
   localparam logic [17:0] WDG_LONG_CYC   = 18'd262128;
   localparam logic [12:0] REC_SHORT_CYC  = 13'd32;
   localparam logic [12:0] REC_LONG_CYC   = 13'd4096;

   typedef enum logic [1:0] {
      WOCFG_TB_INT  = 2'b00,
      WOCFG_TB_RC   = 2'b01,
      WOCFG_TB_XTAL = 2'b10,
      WOCFG_TB_NONE = 2'b11
   } wocfg_tbsel_t;

   typedef enum logic [1:0] {
      WOCFG_MO_NONE = 2'b00,
      WOCFG_MO_INT  = 2'b01,
      WOCFG_MO_RC   = 2'b10,
      WOCFG_MO_XTAL = 2'b11
   } wocfg_mosel_t;

   typedef struct packed {
      logic        lowvoltMonitorReset;
      logic        stopExitByReset;
   } wocfg_sysin_t;

endpackage

// *** verification/wocfg_tb.sv ***
module testbench
   import wocfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic                clk;
   logic                reset_n;
   logic                hsel;
   logic         [31:0] haddr;
   logic         [1:0]  htrans;
   logic                hwrite;
   logic         [2:0]  hsize;
   logic         [31:0] hwdata;
   logic         [31:0] hrdata;
   logic                hreadyout;
   logic                hresp;
   logic                flashProgEnable;
   logic                flashMassErase;
   wocfg_sysin_t        sysIn;
   logic                watchdogDisable;
   logic         [17:0] watchdogTimeout;
   logic                supplyMonitorEnable;
   logic                regulatorMonitorEnable;
   logic                lowvoltMonitorInStop;
   logic                lowvoltResetOut;
   logic         [12:0] stopRecoveryDelay;
   logic                stopInstrEnable;
   logic                internalOscStopRun;
   logic                rcOscStopRun;
   logic                crystalOscStopRun;
   wocfg_tbsel_t        timebaseClockSelect;
   logic                serialBaudFromBus;
   wocfg_mosel_t        mainOscSelect;
   int                  badCount;
   int                  compares;
   int                  cycles;
   int                  seed;
   logic         [31:0] rd;
   logic         [7:0]  v1;
   logic         [7:0]  v2;
   logic         [7:0]  osc;

   wocfg_option_regs DUT (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .flashProgEnable(flashProgEnable), .flashMassErase(flashMassErase), .sysIn(sysIn),
      .watchdogDisable(watchdogDisable), .watchdogTimeout(watchdogTimeout),
      .supplyMonitorEnable(supplyMonitorEnable), .regulatorMonitorEnable(regulatorMonitorEnable),
      .lowvoltMonitorInStop(lowvoltMonitorInStop), .lowvoltResetOut(lowvoltResetOut),
      .stopRecoveryDelay(stopRecoveryDelay), .stopInstrEnable(stopInstrEnable),
      .internalOscStopRun(internalOscStopRun), .rcOscStopRun(rcOscStopRun),
      .crystalOscStopRun(crystalOscStopRun), .timebaseClockSelect(timebaseClockSelect),
      .serialBaudFromBus(serialBaudFromBus), .mainOscSelect(mainOscSelect));

   // ************************************************************
   // Clock, timeout and report
   // ************************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic wrapUp();
      $display("Checks made: %0d, mismatches: %0d", compares, badCount);
      if (badCount == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // The whole run needs well under ten thousand cycles.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         $display("[ERR] %0t run did not finish in time", $time);
         badCount = badCount + 1;
         wrapUp();
      end
   end

   task automatic chk(input bit ok, input string what);
      compares = compares + 1;
      if (!ok) begin
         $display("[ERR] %0t mismatch on %s", $time, what);
         badCount = badCount + 1;
      end
   endtask

   // ************************************************************
   // Bus master and flash helpers
   // ************************************************************
   // The master never assumes zero wait states; only the run timeout ends a wait.
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] r);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      hsize  <= 3'b010;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      r = hrdata;
      chk(hresp === 1'b0 && hreadyout === 1'b1, "bus response");
   endtask

   task automatic resetDut();
      reset_n <= 1'b0;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
   endtask

   task automatic checkOuts(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] o);
      repeat (3) @(posedge clk);
      #1;
      chk(watchdogTimeout === (c1[7] ? 18'd8176 : 18'd262128), "wdg rate");
      chk(lowvoltMonitorInStop === (c1[6] & ~(c1[4] & c1[3])), "lv stop");
      chk(supplyMonitorEnable === ~c1[4], "sup mon");
      chk(regulatorMonitorEnable === ~c1[3], "reg mon");
      chk(stopRecoveryDelay === (c1[2] ? 13'd32 : 13'd4096), "recovery");
      chk(stopInstrEnable === c1[1], "stop en");
      chk(watchdogDisable === c1[0], "wdg dis");
      chk(internalOscStopRun === ~c2[7], "int osc");
      chk(rcOscStopRun === c2[6], "rc osc");
      chk(crystalOscStopRun === c2[5], "xtal osc");
      chk(timebaseClockSelect === wocfg_tbsel_t'(c2[4:3]), "tb sel");
      chk(serialBaudFromBus === c2[0], "baud sel");
      chk(mainOscSelect === wocfg_mosel_t'(o[7:6]), "main osc");
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      reset_n = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'b00; hwrite = 1'b0;
      hsize = 3'b010; hwdata = 32'h0000_0000; flashProgEnable = 1'b0; flashMassErase = 1'b0;
      sysIn = '0; badCount = 0; compares = 0; cycles = 0; seed = 42911;
      for (int i = 0; i < 4; i++) begin
         resetDut();
         ahb(1'b0, 32'(CFG_ONE_ADDR), 32'h0000_0000, rd);
         chk(rd === 32'h0000_0000, "cfg one reset");
         ahb(1'b0, 32'(CFG_TWO_ADDR), 32'h0000_0000, rd);
         chk(rd === 32'h0000_0000, "cfg two reset");
         @(posedge clk) flashMassErase <= 1'b1;
         @(posedge clk) flashMassErase <= 1'b0;
         osc = {i[1:0], 6'h3F};
         flashProgEnable <= 1'b1;
         ahb(1'b1, 32'(OSC_PROG_ADDR), {24'h0000_00, osc}, rd);
         flashProgEnable <= 1'b0;
         checkOuts(8'h00, 8'h00, osc);
         v1 = 8'($random(seed));
         v2 = 8'($random(seed));
         v1[5] = i[0];
         v2[4:3] = i[1:0];
         if (osc[7:6] == 2'b11) begin
            v1[2] = 1'b0;
         end
         if (!v1[5]) begin
            v1[6] = 1'b1;
            v1[4] = 1'b0;
         end
         ahb(1'b1, 32'(CFG_ONE_ADDR), {24'h0000_00, v1}, rd);
         ahb(1'b1, 32'(CFG_TWO_ADDR), {24'h0000_00, v2}, rd);
         ahb(1'b1, 32'(CFG_ONE_ADDR), {24'h0000_00, ~v1}, rd);
         ahb(1'b1, 32'(CFG_TWO_ADDR), {24'h0000_00, ~v2}, rd);
         ahb(1'b1, 32'(OSC_OPT_ADDR), 32'h0000_0000, rd);
         ahb(1'b0, 32'(CFG_ONE_ADDR), 32'h0000_0000, rd);
         chk(rd === {24'h0000_00, v1}, "cfg one once");
         ahb(1'b0, 32'(CFG_TWO_ADDR), 32'h0000_0000, rd);
         chk(rd === {24'h0000_00, v2 & CFG_TWO_MASK}, "cfg two once");
         ahb(1'b0, 32'(OSC_OPT_ADDR), 32'h0000_0000, rd);
         chk(rd === {24'h0000_00, osc}, "option bus write");
         ahb(1'b0, 32'h0000_0100, 32'h0000_0000, rd);
         chk(rd === 32'h0000_0000, "unmapped read");
         checkOuts(v1, v2, osc);
         @(posedge clk) sysIn <= '{lowvoltMonitorReset: 1'b1, stopExitByReset: 1'b1};
         repeat (6) @(posedge clk);
         #1;
         chk(lowvoltResetOut === ~v1[5], "lv reset gate");
         chk(stopRecoveryDelay === 13'd4096, "reset exit delay");
         @(posedge clk) sysIn <= '0;
         $display("Test pass %0d done", i);
      end
      wrapUp();
   end
endmodule
